// ==== core/ext_mem_pkg.sv ====
// Package of constants and carrier types for the external memory controller.
`default_nettype none
package ext_mem_pkg;
  localparam int ADDR_W = 22;                 // Byte address width.
  localparam logic [21:0] TOP_ADDR = 22'h3fffff;
  localparam int WORD_ADDR_W = 21;            // Word address width.
  localparam int DATA_W = 16;
  localparam int CODE_ADDR_W = 17;            // Byte address of code space.
  localparam int SECT_SHIFT = 14;             // Overlay section size power.
  localparam int SECT_NUM = 8;                // Overlay sections in code space.
  localparam int SECT_IDX_W = 3;
  localparam int ROM_ADDR_W = 12;             // Internal ROM reach.
  localparam logic [16:0] ROM_LIMIT = 17'h01000;
  localparam int STRAP_BIT = 0;               // Data pin sensed at reset.
  localparam int SLOW_CYCLES = 4;             // Strobe cycles after reset.
  localparam int FAST_CYCLES = 1;
  localparam int CNT_W = 3;

  typedef enum logic [1:0] {
    ORG_X8 = 2'b00,
    ORG_2X8 = 2'b01,
    ORG_X16 = 2'b10
  } mem_org_e;

  // Request from the core side.
  typedef struct packed {
    logic valid;
    logic code;
    logic write;
    logic byte_op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_s;

  // Pin bundle, all strobes active low.
  typedef struct packed {
    logic code_cs_n;
    logic data_cs_n;
    logic [WORD_ADDR_W-1:0] addr;
    logic shared_lsb_or_high_byte_strobe;
    logic low_write_strobe_n;
    logic read_output_enable_n;
    logic lower_byte_enable_n;
  } mem_pins_s;
endpackage
`default_nettype wire

// ==== core/overlay_map.sv ====
// Overlay translation of code space addresses into top of data space.
`default_nettype none
module overlay_map
  import ext_mem_pkg::*;
(
  input wire logic [CODE_ADDR_W-1:0] code_addr_in,
  input wire logic [SECT_NUM-1:0] sect_en_in,
  input wire logic [ADDR_W-1:0] mem_top_in,
  output logic hit_out,
  output logic [ADDR_W-1:0] data_addr_out
);
  // Section index and its enable; ROM never overlays.
  wire [SECT_IDX_W-1:0] sect;
  wire in_rom;
  wire [ADDR_W-1:0] base;
  assign sect = code_addr_in[CODE_ADDR_W-1:SECT_SHIFT];
  assign in_rom = code_addr_in < ROM_LIMIT; // [R3]
  // Sections stack downward from the top of physical memory.
  assign base = mem_top_in + 22'h1
    - ({19'h0, sect} + 22'h1) * (22'h1 << SECT_SHIFT); // [R4]
  assign hit_out = sect_en_in[sect] & ~in_rom; // [R3] [R4]
  assign data_addr_out = base
    | {8'h0, code_addr_in[SECT_SHIFT-1:0]}; // [R4]
endmodule // overlay_map
`default_nettype wire

// ==== core/ext_mem_ctrl.sv ====
// External code and data memory controller with strap sensing.
// Behaviour
// [R1] Separate chip selects for code space and data space.
// [R2] Address reach of 4 MB, data space up to 2M x 16.
// [R3] Code space reachable via overlay, except internal ROM.
// [R4] Enabled 16 KB overlay sections, 128 KB total, allocated down from top.
// [R5] No speed sensing; slow strobes after reset until firmware speeds up.
// [R6] Host downloads firmware into RAM when no non-volatile code exists.
// [R7] Data SRAM should be 16 bits wide for full protocol rate.
// [R8] At least 128 KB of SRAM, 8 or 16 bits wide.
// [R9] Code and data widths independently 8 or 16 bits.
// [R10] Memory organization taken from a data pin during reset.
// [R11] 8-bit space: shared pin is address LSB, low strobe writes.
// [R12] Two x8 parts: shared pin high byte strobe, low strobe low byte.
// [R13] One x16 part: shared pin upper enable, dedicated pin lower enable.
// [R14] Strobe set follows per-space configuration without glue logic.
// [R15] Each space built from one organization only.
// [R16] Only the accessed space's chip select is active.
// [R17] Byte write to 16-bit space strobes only the addressed byte.
`default_nettype none
module ext_mem_ctrl
  import ext_mem_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire mem_req_s req_in,
  input wire mem_org_e code_org_in,
  input wire logic data_org_fw_in,
  input wire logic fast_clk_in,
  input wire logic [SECT_NUM-1:0] sect_en_in,
  input wire logic [ADDR_W-1:0] mem_top_in,
  input wire logic [DATA_W-1:0] memory_data_bus_in,
  output mem_pins_s pins_out,
  output logic [DATA_W-1:0] memory_data_bus_out,
  output logic [DATA_W-1:0] memory_data_bus_oe_n_out,
  output logic busy_out,
  output logic done_out,
  output logic [DATA_W-1:0] rdata_out,
  output mem_org_e data_org_out
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STROBE = 2'b01,
    ST_HOLD = 2'b10
  } state_e;

  // Sequencer state and the access latched at the take.
  state_e state;
  state_e next_state;
  logic [CNT_W-1:0] cnt;
  logic strap_taken;
  logic in_reset_d;
  mem_req_s cur;
  logic cur_overlay;
  mem_org_e cur_org;
  // Overlay translation of the request on offer.
  wire ovl_hit;
  wire [ADDR_W-1:0] ovl_addr;
  // Effective target of the request on offer.
  wire eff_data;
  wire [ADDR_W-1:0] eff_addr;
  wire mem_org_e eff_org;
  wire [CNT_W-1:0] strobe_len;
  // Sequencer events.
  wire take;
  wire strobe_last;
  wire strobe_on;
  wire hold_on;
  // Attributes of the access in flight, valid from the take onward.
  wire acc_idle;
  wire acc_data;
  wire acc_write;
  wire acc_byte;
  wire acc_a0;
  wire mem_org_e acc_org;
  wire [ADDR_W-1:0] acc_addr;
  wire [DATA_W-1:0] acc_wdata;
  wire hi_sel;
  wire lo_sel;
  wire [2:0] strb;
  // Next values of every registered pin except the write data bus, and of the status outputs.
  wire next_code_cs_n;
  wire next_data_cs_n;
  wire [WORD_ADDR_W-1:0] next_addr;
  wire next_shared;
  wire next_low_we_n;
  wire next_lower_be_n;
  wire next_oe_n;
  wire [DATA_W-1:0] next_bus_oe_n;
  wire next_busy;
  wire next_done;
  wire cap_read;
  wire mem_org_e next_data_org;

  // Decides strobe bits for an organization, byte lane and direction.
  function automatic logic [2:0] strobes(input mem_org_e org,
    input logic wr, input logic hi, input logic lo, input logic a0);
    logic [2:0] s;
    s = 3'h7; // {shared, low write, lower enable}, all inactive high.
    case (org)
      ORG_X8: s = {a0, ~wr, 1'b1}; // [R11]
      ORG_2X8: s = {~(wr & hi), ~(wr & lo), 1'b1}; // [R12] [R17]
      ORG_X16: s = {~hi, ~wr, ~lo}; // [R13] [R17]
      default: s = 3'h7;
    endcase
    return s;
  endfunction

  // Organization chosen by the strap bit and the firmware selection.
  // Only a single x16 part is told apart by the pin; the two x8 flavours
  // look alike to the strap, so firmware has to name the one fitted.
  function automatic mem_org_e strap_org(input logic strap,
    input logic pair);
    mem_org_e org;
    org = ORG_X8;
    if (strap) begin
      org = ORG_X16;
    end else if (pair) begin
      org = ORG_2X8;
    end
    return org;
  endfunction

  // Cycle walk of one access, counted in edges from the take edge c0:
  //   c0   the request is taken; select, address, strobes and write
  //        data are registered from the request itself, so the strobes
  //        already stand in the first cycle after the take.
  //   c1   end of the first strobe cycle; a fast access strobes once.
  //   cN   end of the last strobe cycle; read data is captured here,
  //        after the output enable has stood for the whole cycle.
  //   cN+1 end of the hold cycle, in which strobes are released while
  //        select, address and write data stay for the memory's hold.
  //   After cN+1 the select is released and the sequencer is idle.
  // N is the strobe length: SLOW_CYCLES after reset, FAST_CYCLES once
  // firmware has raised the clock rate. The slow setting costs three
  // extra cycles per access but lets a slow boot part be copied safely.
  // Select and strobes fall on the same edge; the memories need no setup
  // of select ahead of their strobes, and this saves a cycle per access.
  // A request offered while busy is simply not taken; the requester has
  // to hold it until busy rises.

  // Overlay translation for code fetches.
  overlay_map u_ovl (
    .code_addr_in(req_in.addr[CODE_ADDR_W-1:0]),
    .sect_en_in(sect_en_in),
    .mem_top_in(mem_top_in),
    .hit_out(ovl_hit),
    .data_addr_out(ovl_addr)
  );

  // Route overlaid code fetches into data space; each space keeps its org.
  assign eff_data = ~req_in.code | ovl_hit; // [R3]
  assign eff_addr = (req_in.code & ovl_hit) ? ovl_addr
    : (req_in.addr & TOP_ADDR); // [R2]
  assign eff_org = eff_data ? data_org_out : code_org_in; // [R9] [R14]

  // Slow strobes until firmware selects the normal rate; the rate is not
  // sensed, so a wrong setting shows up only as failed reads.
  assign strobe_len = fast_clk_in ? CNT_W'(FAST_CYCLES)
    : CNT_W'(SLOW_CYCLES); // [R5]

  // Sequencer events; a request is only taken once the strap is known.
  assign take = (state == ST_IDLE) & req_in.valid & strap_taken;
  assign strobe_last = (state == ST_STROBE) & (cnt == '0);
  assign strobe_on = (next_state == ST_STROBE);
  assign hold_on = (next_state == ST_HOLD);

  // At the take edge the latch is not loaded yet, so the pins are fed
  // from the request on offer; afterwards from the latched access.
  assign acc_idle = (state == ST_IDLE);
  assign acc_data = acc_idle ? eff_data : cur_overlay;
  assign acc_write = acc_idle ? req_in.write : cur.write;
  assign acc_byte = acc_idle ? req_in.byte_op : cur.byte_op;
  assign acc_addr = acc_idle ? eff_addr : cur.addr;
  assign acc_a0 = acc_addr[0];
  assign acc_org = acc_idle ? eff_org : cur_org;
  assign acc_wdata = acc_idle ? req_in.wdata : cur.wdata;

  // Byte lanes and the strobe set for the access in flight.
  assign hi_sel = ~acc_byte | acc_a0; // [R17]
  assign lo_sel = ~acc_byte | ~acc_a0; // [R17]
  assign strb = strobes(acc_org, acc_write, hi_sel, lo_sel, acc_a0); // [R14]

  // Only the selected space sees its select, from take through hold.
  assign next_code_cs_n = ~((next_state != ST_IDLE)
    & ~acc_data); // [R1] [R16]
  assign next_data_cs_n = ~((next_state != ST_IDLE)
    & acc_data); // [R1] [R16]

  // Word address; the byte bit goes out on the shared pin when needed.
  assign next_addr = acc_addr[ADDR_W-1:1]; // [R2]

  // Strobes stand for the strobe cycles only. An x8 space keeps its
  // address bit on the shared pin through the hold cycle, so the
  // address does not move under the trailing edge of the strobe.
  assign next_shared = strobe_on ? strb[2]
    : (hold_on & (acc_org == ORG_X8)) ? acc_a0 : 1'b1; // [R11] [R12] [R13]
  assign next_low_we_n = strobe_on
    ? (strb[1] | ~acc_write) : 1'b1; // [R11] [R12] [R13]
  assign next_lower_be_n = strobe_on ? strb[0] : 1'b1; // [R13]
  assign next_oe_n = strobe_on ? acc_write : 1'b1; // [R11] [R12] [R13]

  // Write data is driven from the take through the hold cycle, which
  // gives data setup before and hold after the strobe's rising edge.
  assign next_bus_oe_n = ((next_state != ST_IDLE) & acc_write)
    ? '0 : '1;

  // Status, read capture and the strap decode.
  assign next_busy = ~strap_taken | (next_state != ST_IDLE);
  assign next_done = strobe_last; // [R5]
  assign cap_read = strobe_last & ~cur.write;
  assign next_data_org = strap_org(memory_data_bus_in[STRAP_BIT],
    data_org_fw_in); // [R10]

  // Next-state decode.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (take) next_state = ST_STROBE;
      ST_STROBE: if (cnt == '0) next_state = ST_HOLD;
      ST_HOLD: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Capture the organization strap on the first edge after reset release;
  // the pin must still be held by the board on that edge, after reset is released.
  always_ff @(posedge core_clk_in) begin
    in_reset_d <= sys_rst_in;
    if (sys_rst_in) begin
      strap_taken <= 1'b0;
      data_org_out <= ORG_X8;
    end else if (in_reset_d) begin
      strap_taken <= 1'b1;
      data_org_out <= next_data_org; // [R10]
    end
  end

  // Sequencer state and the latched access.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      cnt <= '0;
      cur <= '0;
      cur_overlay <= 1'b0;
      cur_org <= ORG_X8;
    end else begin
      state <= next_state;
      if (take) begin
        cur <= req_in;
        cur.addr <= eff_addr;
        cur_overlay <= eff_data;
        cur_org <= eff_org;
        cnt <= strobe_len - CNT_W'(1); // [R5]
      end else if (cnt != '0) begin
        cnt <= cnt - CNT_W'(1);
      end
    end
  end

  // Pin registers; every pin leaves a flip-flop, so no decode glitch
  // reaches the memories.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pins_out <= '1;
      pins_out.addr <= '0;
      memory_data_bus_oe_n_out <= '1;
      memory_data_bus_out <= '0;
    end else begin
      pins_out.code_cs_n <= next_code_cs_n; // [R1]
      pins_out.data_cs_n <= next_data_cs_n; // [R1]
      pins_out.addr <= next_addr; // [R2]
      pins_out.shared_lsb_or_high_byte_strobe <= next_shared; // [R14]
      pins_out.low_write_strobe_n <= next_low_we_n; // [R14]
      pins_out.lower_byte_enable_n <= next_lower_be_n; // [R14]
      pins_out.read_output_enable_n <= next_oe_n; // [R14]
      memory_data_bus_oe_n_out <= next_bus_oe_n;
      memory_data_bus_out <= acc_wdata;
    end
  end

  // Status and read data capture at the end of the last strobe cycle.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      busy_out <= 1'b1;
      done_out <= 1'b0;
      rdata_out <= '0;
    end else begin
      busy_out <= next_busy;
      done_out <= next_done; // [R5]
      if (cap_read) begin
        rdata_out <= memory_data_bus_in;
      end
    end
  end
endmodule // ext_mem_ctrl
`default_nettype wire

// ==== tb/ext_mem_ctrl_props.sv ====
// Concurrent checks on the memory controller pins.
`default_nettype none
module ext_mem_ctrl_props
  import ext_mem_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire mem_req_s req_in,
  input wire mem_org_e code_org_in,
  input wire logic fast_clk_in,
  input wire mem_pins_s pins_out,
  input wire logic busy_out,
  input wire logic done_out,
  input wire mem_org_e data_org_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  mem_pins_s p;
  mem_req_s r;
  logic tk;
  logic bw;
  logic sh;
  // Aliases; a request is only taken while the controller is idle.
  assign p = pins_out;
  assign r = req_in;
  assign tk = r.valid && !busy_out;
  assign bw = tk && !r.code && r.write && r.byte_op;
  assign sh = p.shared_lsb_or_high_byte_strobe;
  one_sel_a: assert property (p.code_cs_n || p.data_cs_n)
    else $error("both selects low");
  data_sel_a: assert property (tk && !r.code |=> !p.data_cs_n)
    else $error("data select missing");
  word_addr_a: assert property (
    tk && !r.code |=> p.addr == $past(r.addr[21:1]))
    else $error("word address wrong");
  done_fast_a: assert property (
    tk && fast_clk_in |-> ##1 !done_out ##1 done_out)
    else $error("fast done late");
  done_slow_a: assert property (
    tk && !fast_clk_in |-> ##1 (!done_out) [*4] ##1 done_out)
    else $error("slow done wrong");
  lsb_pin_a: assert property (
    tk && r.code && code_org_in == ORG_X8
      |=> !p.data_cs_n || sh == $past(r.addr[0]))
    else $error("lsb pin wrong");
  x16_byte_a: assert property (
    bw && data_org_out == ORG_X16 |=> sh == !$past(r.addr[0])
      && p.lower_byte_enable_n == $past(r.addr[0]))
    else $error("byte enables wrong");
  pair_byte_a: assert property (
    bw && data_org_out == ORG_2X8 |=> sh == !$past(r.addr[0])
      && p.low_write_strobe_n == $past(r.addr[0]))
    else $error("byte strobes wrong");
  rd_strobe_a: assert property (
    tk && !r.write |=> !p.read_output_enable_n && p.low_write_strobe_n)
    else $error("read strobes wrong");
  cover property (tk && r.write);
  cover property (tk && r.code);
  cover property (tk && !fast_clk_in);
endmodule // ext_mem_ctrl_props
bind ext_mem_ctrl ext_mem_ctrl_props props_i (.core_clk_in(core_clk_in),
  .sys_rst_in(sys_rst_in), .req_in(req_in), .code_org_in(code_org_in),
  .fast_clk_in(fast_clk_in), .pins_out(pins_out), .busy_out(busy_out),
  .done_out(done_out), .data_org_out(data_org_out));
`default_nettype wire

// ==== tb/ext_sram_model.sv ====
// Behavioural x16 static memory on the far side of the pins.
`default_nettype none
module ext_sram_model
  import ext_mem_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic strap_in,
  input wire mem_pins_s pins_in,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W-1:0] data_oe_n_in,
  output logic [DATA_W-1:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [65536];
  logic [DATA_W-1:0] last = 16'h0000;
  logic sel;
  logic rd;
  // Both spaces share one array; only the word index is decoded.
  assign sel = !(pins_in.code_cs_n && pins_in.data_cs_n);
  assign rd = sel && !pins_in.read_output_enable_n;
  // A released bus shows no stale data; bit 0 rests on its strap.
  assign data_out = rd ? mem[pins_in.addr[15:0]]
    : {~last[15:1], strap_in};
  // Lanes follow the byte enables, and only a driven bus is stored.
  always @(posedge core_clk_in) begin
    if (rd) last <= mem[pins_in.addr[15:0]];
    if (sel && !pins_in.low_write_strobe_n && !(&data_oe_n_in)) begin
      if (!pins_in.lower_byte_enable_n) begin
        mem[pins_in.addr[15:0]][7:0] <= data_in[7:0];
      end
      if (!pins_in.shared_lsb_or_high_byte_strobe) begin
        mem[pins_in.addr[15:0]][15:8] <= data_in[15:8];
      end
    end
  end
endmodule // ext_sram_model
`default_nettype wire

// ==== tb/external_code_data_memory_controller_tb_top.sv ====
// Self-checking bench for the external memory controller.
`default_nettype none
module external_code_data_memory_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ext_mem_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fast = 1'b1;
  logic org_fw = 1'b0;
  logic strap = 1'b1;
  logic [7:0] sect = 8'h03;
  mem_req_s req = '0;
  mem_org_e code_org = ORG_X16;
  mem_pins_s pins, seen;
  mem_org_e data_org;
  logic [15:0] bus_in, bus_out, oe_n, rdata;
  logic busy, done;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc;
  ext_mem_ctrl uut (.core_clk_in(clk), .sys_rst_in(rst), .req_in(req),
    .code_org_in(code_org), .data_org_fw_in(org_fw), .fast_clk_in(fast),
    .sect_en_in(sect), .mem_top_in(TOP_ADDR), .memory_data_bus_in(bus_in),
    .pins_out(pins), .memory_data_bus_out(bus_out),
    .memory_data_bus_oe_n_out(oe_n), .busy_out(busy), .done_out(done),
    .rdata_out(rdata), .data_org_out(data_org));
  ext_sram_model mem (.core_clk_in(clk), .strap_in(strap), .pins_in(pins),
    .data_in(bus_out), .data_oe_n_in(oe_n), .data_out(bus_in));
  // Core clock at 100 MHz.
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check(string what, logic [31:0] seen_v, logic [31:0] exp);
    checks_done++;
    if (seen_v !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen_v);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // One access; pins are caught in the first strobe cycle, and cyc
  // counts edges from the take to the done pulse.
  task automatic access(logic c, w, b, logic [21:0] a, logic [15:0] d);
    int i;
    for (i = 0; busy && i < 50; i++) @(negedge clk);
    req = '{1'b1, c, w, b, a, d};
    for (i = 0; !busy && i < 50; i++) @(negedge clk);
    req.valid = 1'b0;
    seen = pins;
    for (cyc = 1; !done && cyc < 50; cyc++) @(negedge clk);
    if (done !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  task automatic t_data();
    access(0, 1, 0, 22'h3ffffe, 16'ha5c3);
    check("done cycles", cyc, 2);
    check("selects", {seen.code_cs_n, seen.data_cs_n}, 2'b10);
    access(0, 1, 1, 22'h3fffff, 16'h5555);
    access(0, 1, 1, 22'h3ffffe, 16'h1111);
    check("low enable", seen.lower_byte_enable_n, 0);
    access(0, 0, 0, 22'h3ffffe, 16'h0000);
    check("word read", rdata, 16'h5511);
    $display("data test done");
  endtask
  task automatic t_overlay();
    access(1, 0, 0, 22'h04002, 16'h0000);
    check("overlay select", seen.data_cs_n, 0);
    check("overlay addr", seen.addr,
      (TOP_ADDR + 1 - 2 * 16384 + 2) >> 1);
    access(1, 0, 0, 22'h00002, 16'h0000);
    check("rom select", seen.code_cs_n, 0);
    access(1, 0, 0, 22'h08002, 16'h0000);
    check("off section", seen.code_cs_n, 0);
    $display("overlay test done");
  endtask
  task automatic t_code_org();
    code_org = ORG_X8;
    access(1, 0, 0, 22'h00003, 16'h0000);
    check("lsb pin", seen.shared_lsb_or_high_byte_strobe, 1);
    code_org = ORG_2X8;
    access(1, 1, 1, 22'h00001, 16'h7777);
    check("high strobe", seen.shared_lsb_or_high_byte_strobe, 0);
    check("low strobe", seen.low_write_strobe_n, 1);
    code_org = ORG_X16;
    $display("code width test done");
  endtask
  task automatic t_slow();
    fast = 1'b0;
    access(0, 0, 0, 22'h3ffffe, 16'h0000);
    check("slow cycles", cyc, 5);
    check("slow read", rdata, 16'h5511);
    fast = 1'b1;
    $display("slow test done");
  endtask
  task automatic t_strap();
    strap = 1'b0;
    org_fw = 1'b1;
    do_reset();
    check("pair org", data_org, ORG_2X8);
    access(0, 1, 0, 22'h00010, 16'h1234);
    check("pair strobes", {seen.shared_lsb_or_high_byte_strobe,
      seen.low_write_strobe_n}, 2'b00);
    strap = 1'b1;
    do_reset();
    check("x16 org", data_org, ORG_X16);
    $display("strap test done");
  endtask
  // Main sequence; every wait inside is bounded.
  initial begin
    do_reset();
    t_data();
    t_overlay();
    t_code_org();
    t_slow();
    t_strap();
    give_verdict();
  end
endmodule // external_code_data_memory_controller_tb_top
`default_nettype wire
